// *** mtps_server.sv ***
// modbus tcp pdu server: decode, register access, response build
`timescale 1ns/1ps
`default_nettype none
module mtps_server #(
  parameter int          NCOIL  = 64,
  parameter int          NDISC  = 64,
  parameter int          NINREG = 8,
  parameter int          HAW    = 4,
  parameter logic [15:0] PORT   = mtps_pkg::SERVICE_PORT
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  in_valid_in,
  input  wire logic [7:0]            in_data_in,
  input  wire logic                  in_last_in,
  input  wire logic                  in_client_in,
  output logic                       in_ready_out,
  output logic                       out_valid_out,
  output logic [7:0]                 out_data_out,
  output logic                       out_first_out,
  output logic                       out_last_out,
  output logic                       out_client_out,
  input  wire logic                  out_ready_in,
  input  wire logic [NCOIL-1:0]      coils_in,
  input  wire logic [NDISC-1:0]      discs_in,
  input  wire logic [NINREG*16-1:0]  inregs_in,
  output logic [15:0]                service_port_out,
  output logic [15:0]                served_out
);
  typedef enum logic [1:0] {ST_RX, ST_FETCH, ST_EMIT, ST_FLUSH}
    mtps_state_type;

  // ----------------------------------------------------------------
  // request capture and response sequencing
  // ----------------------------------------------------------------
  mtps_state_type state_q, state_d;
  logic [7:0]  fc_q, fc_d, hi_q, hi_d, exc_q, exc_d;
  logic [15:0] addr_q, addr_d, qty_q, qty_d;
  logic [8:0]  rx_q, rx_d, tx_q, tx_d, len_q, len_d, idx_q, idx_d;
  logic        client_q, client_d, rdy_q, rdy_d;
  logic        ov_q, ov_d, of_q, of_d, ol_q, ol_d;
  logic [7:0]  od_q, od_d, exc_hdr, exc_c, byte_c;
  logic        take, slot, func_ok, is_bit, is_rd, we;
  logic [16:0] span;
  logic [8:0]  word;
  logic [15:0] wdata, rdata, inreg;
  logic [HAW-1:0] waddr, raddr;
  logic [15:0] pos;
  logic [11:0] off;

  assign take = in_valid_in && rdy_q;
  assign slot = !ov_q || out_ready_in;
  assign is_bit = (fc_q == mtps_pkg::FC_RD_COILS) ||
                  (fc_q == mtps_pkg::FC_RD_DISC);
  assign is_rd  = (fc_q == mtps_pkg::FC_RD_HOLD) ||
                  (fc_q == mtps_pkg::FC_RD_INREG);
  assign span = {1'b0, addr_q} + {1'b0, qty_q};
  assign word = (tx_q - mtps_pkg::RESP_DATA) >> 1;
  assign raddr = HAW'(addr_q + {7'h00, word});
  assign inreg = inregs_in[16*(raddr % NINREG) +: 16];

  always_comb begin
    func_ok = is_bit || is_rd || (fc_q == mtps_pkg::FC_WR_SINGLE) ||
              (fc_q == mtps_pkg::FC_WR_MULTI);
    exc_hdr = mtps_pkg::EXC_NONE;
    // unsupported code, quantity out of range or address span past the table
    if (!func_ok) begin
      exc_hdr = mtps_pkg::EXC_FUNCTION;
    end else if (fc_q == mtps_pkg::FC_WR_SINGLE) begin
      if ({1'b0, addr_q} >= 17'(2**HAW)) exc_hdr = mtps_pkg::EXC_ADDRESS;
    end else if (qty_q == 16'h0000) begin
      exc_hdr = mtps_pkg::EXC_VALUE;
    end else if (is_bit && qty_q > mtps_pkg::MAX_BIT_QTY) begin
      exc_hdr = mtps_pkg::EXC_VALUE;
    end else if (!is_bit && qty_q > mtps_pkg::MAX_REG_QTY) begin
      exc_hdr = mtps_pkg::EXC_VALUE;
    end else if ((fc_q == mtps_pkg::FC_RD_COILS && span > 17'(NCOIL)) ||
                 (fc_q == mtps_pkg::FC_RD_DISC  && span > 17'(NDISC)) ||
                 (fc_q == mtps_pkg::FC_RD_INREG && span > 17'(NINREG)) ||
                 (fc_q == mtps_pkg::FC_RD_HOLD && span > 17'(2**HAW)) ||
                 (fc_q == mtps_pkg::FC_WR_MULTI && span > 17'(2**HAW))) begin
      exc_hdr = mtps_pkg::EXC_ADDRESS;
    end
  end

  // short request: header missing bytes, judged in fetch from byte count
  assign exc_c = (func_ok && rx_q < mtps_pkg::HDR_LEN) ?
                 mtps_pkg::EXC_VALUE : exc_hdr;

  always_comb begin
    we    = 1'b0;
    waddr = HAW'(addr_q);
    wdata = {hi_q, in_data_in};
    if (take && rx_q == mtps_pkg::POS_QTY_LO &&
        fc_q == mtps_pkg::FC_WR_SINGLE && exc_hdr == mtps_pkg::EXC_NONE) begin
      we    = 1'b1;
      wdata = {qty_q[15:8], in_data_in};
    end
    // writes land only once the header has been checked
    if (take && rx_q >= mtps_pkg::POS_DATA && rx_q[0] &&
        fc_q == mtps_pkg::FC_WR_MULTI && exc_hdr == mtps_pkg::EXC_NONE &&
        {7'h00, (rx_q - mtps_pkg::POS_DATA) >> 1} < qty_q) begin
      we    = 1'b1;
      waddr = HAW'(addr_q + {8'h00, 8'((rx_q - mtps_pkg::POS_DATA) >> 1)});
    end
  end

  always_comb begin
    off    = 12'h000;
    pos    = 16'h0000;
    byte_c = 8'h00;
    if (exc_q != mtps_pkg::EXC_NONE) begin
      // flagged code, exception code after it
      byte_c = (tx_q == 9'h000) ? (fc_q | mtps_pkg::FC_ERR_FLAG) : exc_q;
    end else if (tx_q == 9'h000) begin
      byte_c = fc_q;
    end else if (is_bit) begin
      // byte count rounds the quantity up
      if (tx_q == 9'h001) begin
        byte_c = 8'((qty_q + 16'h0007) >> 3);
      end else begin
        // sample consecutive points, lsb first, pad 0
        for (int j = 0; j < 8; j++) begin
          off = 12'({tx_q - mtps_pkg::RESP_DATA, 3'b000}) + 12'(j);
          pos = addr_q + {4'h0, off};
          if ({4'h0, off} < qty_q) begin
            byte_c[j] = (fc_q == mtps_pkg::FC_RD_COILS) ?
                        coils_in[pos % NCOIL] : discs_in[pos % NDISC];
          end
        end
      end
    end else if (is_rd) begin
      // two bytes per register, high first
      if (tx_q == 9'h001) begin
        byte_c = {qty_q[6:0], 1'b0};
      end else begin
        byte_c = tx_q[0] ? rdata[7:0] : rdata[15:8];
        if (fc_q == mtps_pkg::FC_RD_INREG) begin
          byte_c = tx_q[0] ? inreg[7:0] : inreg[15:8];
        end
      end
    end else begin
      // write answers echo address and value (single) or quantity (multiple)
      unique case (tx_q)
        mtps_pkg::POS_ADDR_HI: byte_c = addr_q[15:8];
        mtps_pkg::POS_ADDR_LO: byte_c = addr_q[7:0];
        mtps_pkg::POS_QTY_HI:  byte_c = qty_q[15:8];
        default:               byte_c = qty_q[7:0];
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    fc_d = fc_q; hi_d = hi_q; exc_d = exc_q;
    addr_d = addr_q; qty_d = qty_q;
    rx_d = rx_q; tx_d = tx_q; len_d = len_q; idx_d = idx_q;
    client_d = client_q;
    ov_d = ov_q && !out_ready_in;
    od_d = od_q; of_d = of_q; ol_d = ol_q;
    unique case (state_q)
      ST_RX: begin
        if (take) begin
          rx_d = (rx_q == 9'h1FF) ? rx_q : rx_q + 9'h001;
          unique case (rx_q)
            9'h000: begin
              fc_d     = in_data_in;
              client_d = in_client_in;
            end
            mtps_pkg::POS_ADDR_HI: addr_d[15:8] = in_data_in;
            mtps_pkg::POS_ADDR_LO: addr_d[7:0]  = in_data_in;
            mtps_pkg::POS_QTY_HI:  qty_d[15:8]  = in_data_in;
            mtps_pkg::POS_QTY_LO:  qty_d[7:0]   = in_data_in;
            default:               hi_d         = in_data_in;
          endcase
          if (in_last_in) begin
            // a response is only ever built for a request
            state_d = ST_FETCH;
            tx_d    = 9'h000;
          end
        end
      end
      ST_FETCH: begin
        state_d = ST_EMIT;
        // judged after the last byte lands, rx_q now holds the byte count
        if (tx_q == 9'h000) begin
          exc_d = exc_c;
          len_d = mtps_pkg::HDR_LEN;
          if (exc_c != mtps_pkg::EXC_NONE) begin
            len_d = mtps_pkg::EXC_LEN;
          end else if (is_bit) begin
            len_d = mtps_pkg::RESP_DATA + 9'((qty_q + 16'h0007) >> 3);
          end else if (is_rd) begin
            len_d = mtps_pkg::RESP_DATA + {qty_q[7:0], 1'b0};
          end
        end
      end
      ST_EMIT: begin
        if (slot) begin
          ov_d  = 1'b1;
          od_d  = byte_c;
          idx_d = tx_q;
          of_d  = (tx_q == 9'h000);
          ol_d  = (tx_q + 9'h001 == len_q);
          tx_d  = tx_q + 9'h001;
          state_d = (tx_q + 9'h001 == len_q) ? ST_FLUSH : ST_FETCH;
        end
      end
      ST_FLUSH: begin
        rx_d = 9'h000;
        if (slot) state_d = ST_RX;
      end
    endcase
    rdy_d = (state_d == ST_RX);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_RX;
      fc_q <= 8'h00; hi_q <= 8'h00; exc_q <= 8'h00;
      addr_q <= 16'h0000; qty_q <= 16'h0000;
      rx_q <= 9'h000; tx_q <= 9'h000; len_q <= 9'h000; idx_q <= 9'h000;
      client_q <= 1'b0; rdy_q <= 1'b0;
      ov_q <= 1'b0; od_q <= 8'h00; of_q <= 1'b0; ol_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fc_q <= fc_d; hi_q <= hi_d; exc_q <= exc_d;
      addr_q <= addr_d; qty_q <= qty_d;
      rx_q <= rx_d; tx_q <= tx_d; len_q <= len_d; idx_q <= idx_d;
      client_q <= client_d; rdy_q <= rdy_d;
      ov_q <= ov_d; od_q <= od_d; of_q <= of_d; ol_q <= ol_d;
    end
  end

  mtps_regmem #(.AW(HAW)) u_hold (
    .clk_in    (clk_in),
    .we_in     (we),
    .waddr_in  (waddr),
    .wdata_in  (wdata),
    .raddr_in  (raddr),
    .rdata_out (rdata)
  );

  // ----------------------------------------------------------------
  // per client bookkeeping and fixed port
  // ----------------------------------------------------------------
  logic [15:0] port_q;
  logic        done;
  assign done = ov_q && out_ready_in && ol_q;

  always_ff @(posedge clk_in) begin
    // port reads 502 during reset, kept as configured after it, default 502
    port_q <= rst_n_in ? PORT : mtps_pkg::SERVICE_PORT;
  end

  for (genvar c = 0; c < mtps_pkg::NUM_CLIENTS; c++) begin : g_cli
    logic [7:0] cnt_q, cnt_d;
    // each client counted on its own
    always_comb begin
      cnt_d = cnt_q;
      if (done && client_q == 1'(c)) cnt_d = cnt_q + 8'h01;
    end
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) cnt_q <= 8'h00;
      else cnt_q <= cnt_d;
    end
    assign served_out[8*c +: 8] = cnt_q;
  end

  assign in_ready_out     = rdy_q;
  assign out_valid_out    = ov_q;
  assign out_data_out     = od_q;
  assign out_first_out    = of_q;
  assign out_last_out     = ol_q;
  assign out_client_out   = client_q;
  assign service_port_out = port_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ok_code;
    ov_q && of_q && exc_q == mtps_pkg::EXC_NONE |-> od_q == fc_q;
  endproperty
  a_ok_code: assert property (p_ok_code)
    else $error("normal response code differs from request");

  property p_err_code;
    ov_q && of_q && exc_q != mtps_pkg::EXC_NONE |->
      od_q == (fc_q | mtps_pkg::FC_ERR_FLAG);
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("error frame code not flagged");

  property p_err_byte;
    ov_q && idx_q == 9'h001 && exc_q != mtps_pkg::EXC_NONE |->
      od_q == exc_q && ol_q;
  endproperty
  a_err_byte: assert property (p_err_byte)
    else $error("exception code not in second byte");

  property p_no_unsolicited;
    ov_q |-> state_q != ST_RX || $past(state_q) == ST_FLUSH;
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited)
    else $error("response without request");

  property p_addr_lo;
    take && state_q == ST_RX && rx_q == mtps_pkg::POS_ADDR_LO |=>
      addr_q[7:0] == $past(in_data_in) && addr_q[15:8] == $past(addr_q[15:8]);
  endproperty
  a_addr_lo: assert property (p_addr_lo)
    else $error("start address byte misplaced");

  property p_bit_count;
    ov_q && idx_q == 9'h001 && is_bit && exc_q == mtps_pkg::EXC_NONE |->
      od_q == 8'((qty_q + 16'h0007) >> 3) && len_q == 9'(od_q) + 9'h002;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit byte count wrong");

  property p_reg_count;
    ov_q && idx_q == 9'h001 && is_rd && exc_q == mtps_pkg::EXC_NONE |->
      od_q == 8'(qty_q << 1);
  endproperty
  a_reg_count: assert property (p_reg_count)
    else $error("register byte count wrong");

  property p_bad_func;
    state_q == ST_FETCH && tx_q == 9'h000 && !func_ok |=>
      exc_q == mtps_pkg::EXC_FUNCTION ##[1:3] ov_q && of_q;
  endproperty
  a_bad_func: assert property (p_bad_func)
    else $error("unsupported code not refused");

  property p_bit_range;
    state_q == ST_FETCH && tx_q == 9'h000 && is_bit &&
      qty_q > mtps_pkg::MAX_BIT_QTY |=> exc_q == mtps_pkg::EXC_VALUE;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit quantity over limit accepted");

  property p_echo;
    ov_q && idx_q == mtps_pkg::POS_ADDR_HI && exc_q == mtps_pkg::EXC_NONE &&
      fc_q == mtps_pkg::FC_WR_SINGLE |-> od_q == addr_q[15:8] && len_q == 9'h005;
  endproperty
  a_echo: assert property (p_echo)
    else $error("single write not echoed");
endmodule
`default_nettype wire

// *** mtps_pkg.sv ***
// constants used by the pdu server; its register memory uses none of them
package mtps_pkg;
  // ----------------------------------------------------------------
  // function and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FC_RD_COILS   = 8'h01;
  localparam logic [7:0]  FC_RD_DISC    = 8'h02;
  localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
  localparam logic [7:0]  FC_RD_INREG   = 8'h04;
  localparam logic [7:0]  FC_WR_SINGLE  = 8'h06;
  localparam logic [7:0]  FC_WR_MULTI   = 8'h10;
  localparam logic [7:0]  FC_ERR_FLAG   = 8'h80;
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  // ----------------------------------------------------------------
  // limits, byte positions, reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAX_BIT_QTY   = 16'h07D0;
  localparam logic [15:0] MAX_REG_QTY   = 16'h007D;
  localparam logic [15:0] SERVICE_PORT  = 16'h01F6;
  localparam logic [8:0]  POS_ADDR_HI   = 9'h001;
  localparam logic [8:0]  POS_ADDR_LO   = 9'h002;
  localparam logic [8:0]  POS_QTY_HI    = 9'h003;
  localparam logic [8:0]  POS_QTY_LO    = 9'h004;
  localparam logic [8:0]  POS_DATA      = 9'h006;
  localparam logic [8:0]  HDR_LEN       = 9'h005;
  localparam logic [8:0]  EXC_LEN       = 9'h002;
  localparam logic [8:0]  RESP_DATA     = 9'h002;
  localparam int          NUM_CLIENTS   = 2;
endpackage

// *** mtps_regmem.sv ***
// holding register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mtps_regmem #(
  parameter int AW = 4
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [15:0]   wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [15:0]   rdata_out
);
  logic [15:0] mem_q [2**AW];
  logic [15:0] rdata_q;

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
    rdata_q <= mem_q[raddr_in];
  end

  assign rdata_out = rdata_q;
endmodule
`default_nettype wire

// *** mtps_client.sv ***
// modbus tcp client model: sends request pdus and sinks responses
`timescale 1ns/1ps
`default_nettype none
module mtps_client (
  input  wire logic       clk_in,
  output logic            req_valid_out,
  output logic [7:0]      req_data_out,
  output logic            req_last_out,
  output logic            req_client_out,
  input  wire logic       req_ready_in,
  input  wire logic       rsp_valid_in,
  input  wire logic [7:0] rsp_data_in,
  input  wire logic       rsp_first_in,
  input  wire logic       rsp_last_in,
  input  wire logic       rsp_client_in,
  output logic            rsp_ready_out
);
  logic [7:0] rsp_q[$];
  logic       rsp_cl;
  int         first_bad;
  int         tmo;

  initial begin
    req_valid_out  = 1'b0;
    req_data_out   = 8'h5A;
    req_last_out   = 1'b0;
    req_client_out = 1'b0;
    rsp_ready_out  = 1'b0;
    tmo            = 0;
  end

  // ----------------------------------------------------------------
  // request side
  // ----------------------------------------------------------------
  // code leads, port handled upstream
  task automatic send(input logic [7:0] pdu[$], input logic cl);
    int n;
    foreach (pdu[i]) begin
      req_valid_out  = 1'b1;
      req_data_out   = pdu[i];
      req_last_out   = (i == pdu.size() - 1);
      req_client_out = cl;
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (req_ready_in !== 1'b1 && n < 500);
      if (n >= 500)
        tmo++;
      #1;
    end
    // released lines show the inverse, never the stale byte
    req_valid_out = 1'b0;
    req_last_out  = 1'b0;
    req_data_out  = ~req_data_out;
  endtask

  // ----------------------------------------------------------------
  // response side
  // ----------------------------------------------------------------
  task automatic recv(input logic slow);
    int   n;
    logic done;
    rsp_q     = {};
    first_bad = 0;
    done      = 1'b0;
    n         = 0;
    while (!done && n < 4000) begin
      // slow sink stalls two cycles out of three
      rsp_ready_out = !(slow && (n % 3 != 2));
      @(posedge clk_in);
      n++;
      if (rsp_valid_in === 1'b1 && rsp_ready_out) begin
        if (rsp_q.size() == 0)
          rsp_cl = rsp_client_in;
        if (rsp_first_in !== (rsp_q.size() == 0))
          first_bad++;
        rsp_q.push_back(rsp_data_in);
        done = (rsp_last_in === 1'b1);
      end
      #1;
    end
    if (!done)
      tmo++;
    rsp_ready_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** mtps_server_bench.sv ***
// self-checking bench for the pdu server against the client model
`timescale 1ns/1ps
`default_nettype none
module mtps_server_bench;
  localparam int NCOIL = 2000;
  logic               clk_in;
  logic               rst_n_in;
  logic               iv, il, ic, ir, ov, of, ol, oc, ordy;
  logic [7:0]         id, od;
  logic [NCOIL-1:0]   coils;
  logic [63:0]        discs;
  logic [127:0]       inregs;
  logic [15:0]        port, served;
  int                 fail_count;
  int                 tests_run;

  mtps_server #(.NCOIL(NCOIL), .NDISC(64), .NINREG(8), .HAW(4)) i_mtps_server (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .in_valid_in(iv), .in_data_in(id),
    .in_last_in(il), .in_client_in(ic), .in_ready_out(ir),
    .out_valid_out(ov), .out_data_out(od), .out_first_out(of),
    .out_last_out(ol), .out_client_out(oc), .out_ready_in(ordy),
    .coils_in(coils), .discs_in(discs), .inregs_in(inregs),
    .service_port_out(port), .served_out(served));

  mtps_client i_mtps_client (
    .clk_in(clk_in), .req_valid_out(iv), .req_data_out(id),
    .req_last_out(il), .req_client_out(ic), .req_ready_in(ir),
    .rsp_valid_in(ov), .rsp_data_in(od), .rsp_first_in(of),
    .rsp_last_in(ol), .rsp_client_in(oc), .rsp_ready_out(ordy));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run(input string what, input logic [7:0] req[$],
                     input logic cl, input logic slow,
                     input logic [7:0] e[$]);
    i_mtps_client.send(req, cl);
    i_mtps_client.recv(slow);
    if (i_mtps_client.tmo != 0) begin
      fail_count++;
      end_sim();
    end
    check({what, " len"}, 16'(i_mtps_client.rsp_q.size()), 16'(e.size()));
    check({what, " client"}, 16'(i_mtps_client.rsp_cl), 16'(cl));
    check({what, " first"}, 16'(i_mtps_client.first_bad), 16'h0000);
    foreach (e[i])
      if (i < i_mtps_client.rsp_q.size())
        check({what, " byte"}, 16'(i_mtps_client.rsp_q[i]), 16'(e[i]));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("ready in reset", 16'(ir), 16'h0000);
    check("served in reset", served, 16'h0000);
    check("port", port, 16'h01F6);
  endtask

  task automatic t_coils();
    logic [7:0] e[$];
    repeat (4) @(posedge clk_in);
    #1;
    check("idle valid", 16'(ov), 16'h0000);
    e = {8'h01, 8'h02, coils[10:3], 8'(coils[12:11])};
    run("rc", {8'h01, 8'h00, 8'h03, 8'h00, 8'h0A}, 1'b0, 1'b0, e);
    check("served0", served, 16'h0001);
    e = {8'h01, 8'h01, 8'(coils[260:258])};
    run("rc hi", {8'h01, 8'h01, 8'h02, 8'h00, 8'h03}, 1'b0, 1'b0, e);
    e = {8'h01, 8'hFA};
    for (int i = 0; i < 250; i++)
      e.push_back(coils[8*i+:8]);
    run("rc max", {8'h01, 8'h00, 8'h00, 8'h07, 8'hD0}, 1'b0, 1'b1, e);
    run("rc over", {8'h01, 8'h00, 8'h00, 8'h07, 8'hD1}, 1'b0, 1'b0,
        {8'h81, 8'h03});
    run("rc zero", {8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b0,
        {8'h81, 8'h03});
    run("rc range", {8'h01, 8'h00, 8'h01, 8'h07, 8'hD0}, 1'b0, 1'b0,
        {8'h81, 8'h02});
  endtask

  task automatic t_discs();
    logic [7:0] e[$];
    e = {8'h02, 8'h02, discs[62:55], 8'(discs[63])};
    run("rd", {8'h02, 8'h00, 8'h37, 8'h00, 8'h09}, 1'b1, 1'b0, e);
    run("rd range", {8'h02, 8'h00, 8'h38, 8'h00, 8'h09}, 1'b1, 1'b0,
        {8'h82, 8'h02});
  endtask

  task automatic t_inregs();
    run("ri", {8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, 1'b0, 1'b1,
        {8'h04, 8'h04, 8'h10, 8'h01, 8'h20, 8'h02});
    run("ri qty", {8'h04, 8'h00, 8'h00, 8'h00, 8'h7E}, 1'b0, 1'b0,
        {8'h84, 8'h03});
  endtask

  task automatic t_holding();
    run("ws", {8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, 1'b1, 1'b1,
        {8'h06, 8'h00, 8'h05, 8'h12, 8'h34});
    check("served1", 16'(served[15:8]), 16'h0001);
    run("wm", {8'h10, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'hAB, 8'hCD,
        8'h00, 8'h01}, 1'b0, 1'b0, {8'h10, 8'h00, 8'h02, 8'h00, 8'h02});
    run("rh", {8'h03, 8'h00, 8'h02, 8'h00, 8'h02}, 1'b1, 1'b0,
        {8'h03, 8'h04, 8'hAB, 8'hCD, 8'h00, 8'h01});
    run("rh ws", {8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, 1'b0, 1'b0,
        {8'h03, 8'h02, 8'h12, 8'h34});
    run("ws range", {8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 1'b0, 1'b0,
        {8'h86, 8'h02});
    run("rh short", {8'h03, 8'h00, 8'h00}, 1'b0, 1'b0,
        {8'h83, 8'h03});
  endtask

  task automatic t_badcode();
    logic [7:0] codes[3] = '{8'h05, 8'h07, 8'h2B};
    foreach (codes[k])
      run("bad", {codes[k], 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1, 1'b0,
          {codes[k] | 8'h80, 8'h01});
  endtask

  initial begin
    fail_count = 0;
    tests_run  = 0;
    rst_n_in   = 1'b0;
    coils      = {125{16'hC3A5}};
    discs      = 64'h0123456789ABCDEF;
    inregs     = 128'h70076006500540043003200210010F0F;
    repeat (8) @(posedge clk_in);
    #1;
    t_reset();
    rst_n_in = 1'b1;
    t_coils();
    t_holding();
    t_discs();
    t_inregs();
    t_badcode();
    end_sim();
  end
endmodule
`default_nettype wire
